// ### hdl/umc_mode_irq.sv
// umc_mode_irq: mode register, interrupt mask, line routing, receive filter
// and smart-card retry control of a serial port, behind an AXI4-Lite slave.
// assumes one clock, synchronous inputs and a core that supplies pulses for
// received characters and level status flags for the interrupt sources.
`timescale 1ns/1ps
`default_nettype none

module umc_mode_irq #(
	parameter int ADDR_W = 12
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              rx_pin,
	input  wire logic              tx_core,
	input  wire logic              sample_tick,
	input  wire logic              rx_char_done,
	input  wire logic              rx_parity_bad,
	input  wire logic              iter_clear,
	input  wire logic [31:0]       irq_status,
	output logic                   tx_pin,
	output logic                   rx_core,
	output logic                   sck_oe_n,
	output logic                   neg_ack_seen_send,
	output logic                   iter_flag,
	output logic                   irq,
	output logic                   sync_mode,
	output logic [2:0]             parity_type_field,
	output logic [2:0]             stop_halves,
	output logic [1:0]             channel_loop_mode,
	output logic                   bit_order_select,
	output logic [3:0]             char_bits,
	output logic                   oversample_8x,
	output logic                   var_sync,
	output logic                   line_code_enable,
	output logic                   single_pulse_delimiter
);
	import umc_pkg::*;

	// the decoder looks at the low 8 address bits only
	if (ADDR_W < 8) begin : g_chk
		$error("umc_mode_irq: ADDR_W must be at least 8");
	end

	typedef struct packed {
		logic [31:0] mr;
		logic [31:0] mask;
		logic [7:0]  aw_addr;
		logic        aw_have;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        w_have;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [2:0]  flt;
		logic        rx_flt;
		logic        tx_pin;
		logic        rx_core;
		logic [2:0]  err_cnt;
		logic        iter_flag;
		logic        neg_ack_seen_send;
		logic        irq;
		logic [3:0]  char_bits;
		logic [2:0]  stop_halves;
		logic        sck_oe_n;
	} umc_state_s;

	umc_state_s  s;
	umc_state_s  next_s;
	logic        wr_do;
	logic [31:0] eff_status;

	// byte strobes widened to a bit mask
	function automatic logic [31:0] strb_mask(input logic [3:0] st);
		strb_mask = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
	endfunction

	// 2-of-3 majority of the filter samples
	function automatic logic maj3(input logic [2:0] v);
		maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// a write runs once address and data are both held and no answer waits
	assign wr_do      = s.aw_have & s.w_have & ~s.bvalid;
	// retry-limit flag is this block's own source, merged into the status
	assign eff_status = irq_status | ({31'h0000_0000, s.iter_flag} << ITER_SRC);

	// next-state logic for bus, configuration and line control
	always_comb begin
		logic [31:0] wm;
		logic [31:0] sm;
		logic        iso;
		wm     = strb_mask(s.w_strb) & MR_WMASK;
		sm     = strb_mask(s.w_strb) & IRQ_VALID & s.w_data;
		iso    = (s.mr[MODE_LSB +: 4] == MODE_ISO_T0) ||
		         (s.mr[MODE_LSB +: 4] == MODE_ISO_T1);
		next_s = s;
		next_s.neg_ack_seen_send = 1'b0;
		// address and data channels are taken independently
		if (s.awready && awvalid) begin
			next_s.aw_have = 1'b1;
			next_s.aw_addr = awaddr[7:0];
		end
		if (s.wready && wvalid) begin
			next_s.w_have = 1'b1;
			next_s.w_data = wdata;
			next_s.w_strb = wstrb;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end
		if (wr_do) begin
			next_s.aw_have = 1'b0;
			next_s.w_have  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = RESP_OKAY;
			case (s.aw_addr)
				MR_OFS: begin
					next_s.mr = (s.mr & ~wm) | (s.w_data & wm);
				end
				IER_OFS: begin
					next_s.mask = s.mask | sm;
				end
				IDR_OFS: begin
					next_s.mask = s.mask & ~sm;
				end
				default: begin
					next_s.bresp = RESP_SLVERR;
				end
			endcase
		end
		// ready is withheld while a channel's item is parked
		next_s.awready = ~next_s.aw_have;
		next_s.wready  = ~next_s.w_have;

		// read channel: one read in flight, data captured at the handshake
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s.arready && arvalid) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = RESP_OKAY;
			case (araddr[7:0])
				MR_OFS: begin
					next_s.rdata = s.mr;
				end
				IMR_OFS: begin
					next_s.rdata = s.mask;
				end
				CSR_OFS: begin
					next_s.rdata = eff_status;
				end
				default: begin
					next_s.rdata = 32'h0000_0000;
					next_s.rresp = RESP_SLVERR;
				end
			endcase
		end
		next_s.arready = ~next_s.rvalid;

		// decoded character length and stop bit count
		if (s.mr[NINE_BIT]) begin
			next_s.char_bits = CHAR_NINE;
		end else begin
			next_s.char_bits = CHAR_BASE + {2'b00, s.mr[CHAR_LEN_LSB +: 2]};
		end
		unique case (s.mr[STOP_LSB +: 2])
			2'h1:    next_s.stop_halves = STOP_ONEHALF;
			2'h2:    next_s.stop_halves = STOP_TWO;
			default: next_s.stop_halves = STOP_ONE;
		endcase
		// clock pin driven only for an internal clock source
		next_s.sck_oe_n = ~(s.mr[CLKO_BIT] &&
		                   (s.mr[CLKS_LSB +: 2] != CLKS_EXT));

		// receive filter samples at the 1/16-bit tick; a bypassed filter
		// still shifts so that enabling it starts from real samples
		if (sample_tick) begin
			next_s.flt = {s.flt[1:0], rx_pin};
		end
		if (!s.mr[FILTER_BIT]) begin
			next_s.rx_flt = rx_pin;
		end else if (sample_tick) begin
			next_s.rx_flt = maj3(next_s.flt);
		end

		// channel routing; local loopback idles the pin at mark level
		unique case (s.mr[LOOP_LSB +: 2])
			CH_NORMAL: begin
				next_s.tx_pin  = tx_core;
				next_s.rx_core = s.rx_flt;
			end
			CH_ECHO: begin
				next_s.tx_pin  = s.rx_flt;
				next_s.rx_core = s.rx_flt;
			end
			CH_LOCAL: begin
				next_s.tx_pin  = 1'b1;
				next_s.rx_core = tx_core;
			end
			CH_REMOTE: begin
				next_s.tx_pin  = rx_pin;
				next_s.rx_core = 1'b1;
			end
		endcase

		// smart-card negative acknowledge; clear first so a set wins
		if (iter_clear) begin
			next_s.iter_flag = 1'b0;
		end
		if (rx_char_done && iso) begin
			if (!rx_parity_bad) begin
				next_s.err_cnt = 3'h0;
			end else if (!s.mr[ERRLIM_BIT]) begin
				next_s.neg_ack_seen_send = ~s.mr[INHIBIT_BIT];
			end else if (s.err_cnt < s.mr[ITER_LSB +: 3]) begin
				next_s.neg_ack_seen_send = ~s.mr[INHIBIT_BIT];
				next_s.err_cnt   = s.err_cnt + 3'h1;
			end else begin
				next_s.iter_flag = 1'b1;
			end
		end

		// one interrupt line from the unmasked flags
		next_s.irq = |(eff_status & s.mask);
	end

	// state register, synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s         <= '0;
			s.mr      <= MR_RST;
			s.mask    <= MASK_RST;
			s.awready <= 1'b1;
			s.wready  <= 1'b1;
			s.arready <= 1'b1;
			s.tx_pin  <= 1'b1;
			s.rx_core <= 1'b1;
			s.rx_flt  <= 1'b1;
			s.flt     <= 3'h7;
			s.sck_oe_n <= 1'b1;
			s.char_bits   <= CHAR_BASE;
			s.stop_halves <= STOP_ONE;
		end else begin
			s <= next_s;
		end
	end

	// outputs are flip-flop fields or slices of the mode register
	assign awready                = s.awready;
	assign wready                 = s.wready;
	assign bvalid                 = s.bvalid;
	assign bresp                  = s.bresp;
	assign arready                = s.arready;
	assign rvalid                 = s.rvalid;
	assign rdata                  = s.rdata;
	assign rresp                  = s.rresp;
	assign tx_pin                 = s.tx_pin;
	assign rx_core                = s.rx_core;
	assign sck_oe_n               = s.sck_oe_n;
	assign neg_ack_seen_send              = s.neg_ack_seen_send;
	assign iter_flag              = s.iter_flag;
	assign irq                    = s.irq;
	assign char_bits              = s.char_bits;
	assign stop_halves            = s.stop_halves;
	assign sync_mode              = s.mr[SYNC_BIT];
	assign parity_type_field      = s.mr[PARITY_LSB +: 3];
	assign channel_loop_mode      = s.mr[LOOP_LSB +: 2];
	assign bit_order_select       = s.mr[ORDER_BIT];
	assign oversample_8x          = s.mr[OVER_BIT];
	assign var_sync               = s.mr[VSYNC_BIT];
	assign line_code_enable       = s.mr[CODING_BIT];
	assign single_pulse_delimiter = s.mr[DELIM_BIT];

	// checks on the block's own behaviour
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	ier_set_a: assert property (
		wr_do && s.aw_addr == IER_OFS && s.w_strb == 4'hF |=>
		((s.mask & $past(s.w_data) & IRQ_VALID) ==
		 ($past(s.w_data) & IRQ_VALID)) &&
		((s.mask & ~$past(s.w_data)) == ($past(s.mask) & ~$past(s.w_data))))
		else $error("enable write did not set its mask bits");

	idr_clr_a: assert property (
		wr_do && s.aw_addr == IDR_OFS && s.w_strb == 4'hF |=>
		((s.mask & $past(s.w_data)) == 32'h0000_0000) &&
		((s.mask & ~$past(s.w_data)) == ($past(s.mask) & ~$past(s.w_data))))
		else $error("disable write did not clear its mask bits");

	mask_map_a: assert property (
		(s.mask & ~IRQ_VALID) == 32'h0000_0000)
		else $error("mask holds a bit with no interrupt source");

	irq_out_a: assert property (
		##1 irq == |($past(eff_status) & $past(s.mask)))
		else $error("interrupt line disagrees with masked flags");

	sck_drive_a: assert property (
		##1 sck_oe_n == !($past(s.mr[CLKO_BIT]) &&
		                  $past(s.mr[CLKS_LSB +: 2]) != CLKS_EXT))
		else $error("clock pin enable wrong for clock selection");

	local_loop_a: assert property (
		s.mr[LOOP_LSB +: 2] == CH_LOCAL |=>
		rx_core == $past(tx_core) && tx_pin)
		else $error("local loopback did not feed transmitter back");

	remote_loop_a: assert property (
		s.mr[LOOP_LSB +: 2] == CH_REMOTE |=> tx_pin == $past(rx_pin))
		else $error("remote loopback did not pass receive pin");

	neg_ack_seen_plain_a: assert property (
		rx_char_done && rx_parity_bad && !s.mr[ERRLIM_BIT] &&
		!s.mr[INHIBIT_BIT] && s.mr[MODE_LSB +: 4] == MODE_ISO_T0 |=>
		neg_ack_seen_send)
		else $error("parity error was not answered with a neg_ack_seen");

	neg_ack_seen_inhibit_a: assert property (
		s.mr[INHIBIT_BIT] |=> !neg_ack_seen_send)
		else $error("neg_ack_seen sent while inhibited");

	limit_hit_a: assert property (
		rx_char_done && rx_parity_bad && s.mr[ERRLIM_BIT] &&
		s.mr[MODE_LSB +: 4] == MODE_ISO_T0 &&
		s.err_cnt == s.mr[ITER_LSB +: 3] |=> iter_flag && !neg_ack_seen_send)
		else $error("retry limit reached without flag");

	char_len_a: assert property (
		s.mr[NINE_BIT] ##1 $stable(s.mr[NINE_BIT]) |-> char_bits == CHAR_NINE)
		else $error("nine-bit mode did not give 9-bit characters");
endmodule

`default_nettype wire

// ### hdl/umc_pkg.sv
// umc_pkg: register map, field positions and codes of the serial mode and
// interrupt-mask block; shared by the design and its bench.
// assumes a 32-bit AXI4-Lite register bus, byte offsets in the low 8 bits.
package umc_pkg;
	// register byte offsets
	localparam logic [7:0]  MR_OFS       = 8'h04;
	localparam logic [7:0]  IER_OFS      = 8'h08;
	localparam logic [7:0]  IDR_OFS      = 8'h0C;
	localparam logic [7:0]  IMR_OFS      = 8'h10;
	localparam logic [7:0]  CSR_OFS      = 8'h14;
	// mode register field positions
	localparam int          MODE_LSB     = 0;
	localparam int          CLKS_LSB     = 4;
	localparam int          CHAR_LEN_LSB = 6;
	localparam int          SYNC_BIT     = 8;
	localparam int          PARITY_LSB   = 9;
	localparam int          STOP_LSB     = 12;
	localparam int          LOOP_LSB     = 14;
	localparam int          ORDER_BIT    = 16;
	localparam int          NINE_BIT     = 17;
	localparam int          CLKO_BIT     = 18;
	localparam int          OVER_BIT     = 19;
	localparam int          INHIBIT_BIT  = 20;
	localparam int          ERRLIM_BIT   = 21;
	localparam int          VSYNC_BIT    = 22;
	localparam int          ITER_LSB     = 24;
	localparam int          FILTER_BIT   = 28;
	localparam int          CODING_BIT   = 29;
	localparam int          DELIM_BIT    = 31;
	// writable bits, reset values, valid interrupt sources
	localparam logic [31:0] MR_WMASK     = 32'hB77F_FFFF;
	localparam logic [31:0] MR_RST       = 32'h0000_0000;
	localparam logic [31:0] MASK_RST     = 32'h0000_0000;
	localparam logic [31:0] IRQ_VALID    = 32'h001F_3FFF;
	localparam int          ITER_SRC     = 10;
	// codes
	localparam logic [1:0]  CLKS_EXT     = 2'h3;
	localparam logic [1:0]  CH_NORMAL    = 2'h0;
	localparam logic [1:0]  CH_ECHO      = 2'h1;
	localparam logic [1:0]  CH_LOCAL     = 2'h2;
	localparam logic [1:0]  CH_REMOTE    = 2'h3;
	localparam logic [3:0]  MODE_ISO_T0  = 4'h4;
	localparam logic [3:0]  MODE_ISO_T1  = 4'h6;
	localparam logic [3:0]  CHAR_BASE    = 4'h5;
	localparam logic [3:0]  CHAR_NINE    = 4'h9;
	localparam logic [2:0]  STOP_ONE     = 3'h2;
	localparam logic [2:0]  STOP_ONEHALF = 3'h3;
	localparam logic [2:0]  STOP_TWO     = 3'h4;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage

// ### tb/test_usart_mode_and_irq_config.sv
// test_usart_mode_and_irq_config: table-driven bench of umc_mode_irq.
// assumes umc_pkg and umc_peer; one 20 MHz clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	bad_count++; $display("Error %0t: got %h want %h", $time, a, b); end end
module test_usart_mode_and_irq_config;
	import umc_pkg::*;
	logic        aclk = 0, aresetn = 0, send_lvl = 1;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, irq_status = '0, rdata, rd_d;
	logic [3:0]  wstrb = 4'hF, char_bits;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp, channel_loop_mode, tcnt = '0;
	logic        rx_pin, tx_core = 1, sample_tick = 0, rx_char_done = 0;
	logic        rx_parity_bad = 0, iter_clear = 0, tx_pin, rx_core, lo;
	logic        sck_oe_n, neg_ack_seen_send, iter_flag, irq, sync_mode;
	logic [2:0]  parity_type_field, stop_halves;
	logic        bit_order_select, oversample_8x, var_sync;
	logic        line_code_enable, single_pulse_delimiter;
	int          bad_count = 0, num_checks = 0;
	// mode words and {char_bits, stop_halves, sck_oe_n} they should give;
	// no word uses a reserved stop, mode or clock code
	logic [31:0] mv [8] = '{32'h0000_0000, 32'h0004_10C0, 32'h0007_6270,
		32'h000C_8590, 32'hB040_C600, 32'h0000_0800, 32'h0000_0E00,
		32'hFFFF_EFF6};
	logic [7:0]  ex [8] = '{8'h55, 8'h86, 8'h99, 8'h74, 8'h55, 8'h55, 8'h55,
		8'h99};

	umc_mode_irq i_umc_mode_irq (.*);
	umc_peer i_umc_peer (.aclk(aclk), .send_lvl(send_lvl), .rx_pin(rx_pin));

	always #25 aclk = ~aclk;
	// filter sample pulse every 4 clocks stands in for the 1/16-bit tick
	always @(posedge aclk) begin
		tcnt <= tcnt + 2'd1;
		sample_tick <= (tcnt == 2'd3);
	end

	task automatic report_and_stop();
		if (bad_count == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ap;
		bit wp;
		@(posedge aclk);
		awaddr <= {4'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ap = 1;
		wp = 1;
		while (ap || wp) begin
			@(posedge aclk);
			if (ap && awready) begin
				ap = 0;
				awvalid <= 1'b0;
			end
			if (wp && wready) begin
				wp = 0;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge aclk);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= {4'h0, a};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rd_d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// one received character; the neg_ack_seen pulse may land in either next cycle
	task automatic chr(input logic bad, input logic expn);
		logic seen;
		@(posedge aclk);
		rx_char_done <= 1'b1;
		rx_parity_bad <= bad;
		@(posedge aclk);
		rx_char_done <= 1'b0;
		#1 seen = neg_ack_seen_send;
		@(posedge aclk);
		#1 seen = seen | neg_ack_seen_send;
		`CHK(seen, expn)
	endtask

	task automatic line_chk(input logic [1:0] m, input logic r, input logic t);
		logic [1:0] e;
		@(posedge aclk);
		send_lvl <= r;
		tx_core <= t;
		repeat (5) @(posedge aclk);
		case (m)
			CH_NORMAL: e = {t, r};
			CH_ECHO:   e = {r, r};
			CH_LOCAL:  e = {1'b1, t};
			default:   e = {r, 1'b1};
		endcase
		#1 `CHK({tx_pin, rx_core}, e)
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge aclk);
		#1 `CHK({irq, tx_pin, sck_oe_n, char_bits, stop_halves}, 10'h1AA)
		@(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			wr(MR_OFS, mv[i]);
			rd(MR_OFS);
			`CHK(rd_d, mv[i] & MR_WMASK)
			`CHK({char_bits, stop_halves, sck_oe_n}, ex[i])
			`CHK({sync_mode, parity_type_field, channel_loop_mode, bit_order_select,
				oversample_8x, var_sync, line_code_enable, single_pulse_delimiter},
				{mv[i][8], mv[i][11:9], mv[i][15:14], mv[i][16], mv[i][19],
				mv[i][22], mv[i][29], mv[i][31]})
		end
		// each loop mode with both line polarities
		for (int m = 0; m < 4; m++) begin
			wr(MR_OFS, 32'(m) << LOOP_LSB);
			line_chk(2'(m), 1'b0, 1'b1);
			line_chk(2'(m), 1'b1, 1'b0);
		end
		// one-sample glitch: swallowed only with the filter on
		for (int f = 1; f >= 0; f--) begin
			wr(MR_OFS, f ? 32'h1000_0000 : 32'h0000_0000);
			send_lvl <= 1'b0;
			repeat (4) @(posedge aclk);
			send_lvl <= 1'b1;
			lo = 1'b0;
			repeat (12) begin
				@(posedge aclk);
				#1 lo = lo | !rx_core;
			end
			`CHK(lo, 1'(f == 0))
		end
		wr(MR_OFS, 32'h1000_0000);
		send_lvl <= 1'b0;
		repeat (16) @(posedge aclk);
		`CHK(rx_core, 1'b0)
		send_lvl <= 1'b1;
		// smart card T=0, limited nacks, limit 2
		wr(MR_OFS, 32'h0220_0004);
		chr(1'b1, 1'b1);
		chr(1'b0, 1'b0);
		chr(1'b1, 1'b1);
		chr(1'b1, 1'b1);
		chr(1'b1, 1'b0);
		`CHK(iter_flag, 1'b1)
		// the retry-limit flag also shows in the status word
		rd(CSR_OFS);
		`CHK(rd_d, 32'h0000_0400)
		iter_clear <= 1'b1;
		@(posedge aclk);
		iter_clear <= 1'b0;
		@(posedge aclk);
		#1 `CHK(iter_flag, 1'b0)
		wr(MR_OFS, 32'h0000_0004);
		repeat (3) chr(1'b1, 1'b1);
		wr(MR_OFS, 32'h0010_0004);
		chr(1'b1, 1'b0);
		// mask set and clear; writing zero leaves bits alone
		@(posedge aclk);
		irq_status <= 32'h0010_0000;
		wr(IER_OFS, 32'h0000_0005);
		wr(IER_OFS, 32'h0000_0002);
		rd(IMR_OFS);
		`CHK(rd_d, 32'h0000_0007)
		wr(IDR_OFS, 32'h0000_0004);
		rd(IMR_OFS);
		`CHK(rd_d, 32'h0000_0003)
		`CHK(irq, 1'b0)
		wr(IER_OFS, 32'hFFFF_FFFF);
		rd(IMR_OFS);
		`CHK(rd_d, IRQ_VALID)
		`CHK(irq, 1'b1)
		wr(IDR_OFS, 32'h001F_3FFB);
		rd(IMR_OFS);
		`CHK(rd_d, 32'h0000_0004)
		`CHK(irq, 1'b0)
		irq_status <= 32'h0000_0004;
		repeat (3) @(posedge aclk);
		`CHK(irq, 1'b1)
		rd(CSR_OFS);
		`CHK(rd_d, 32'h0000_0004)
		// unmapped and wrong-direction accesses
		wr(8'h40, 32'h1234_5678);
		`CHK(resp, RESP_SLVERR)
		rd(8'h40);
		`CHK({resp, rd_d}, {RESP_SLVERR, 32'h0000_0000})
		rd(IDR_OFS);
		`CHK(resp, RESP_SLVERR)
		// reset in mid-run clears mode and mask
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(MR_OFS);
		`CHK(rd_d, MR_RST)
		rd(IMR_OFS);
		`CHK({rd_d, irq}, {MASK_RST, 1'b0})
		report_and_stop();
	end
endmodule
`default_nettype wire

// ### tb/umc_peer.sv
// umc_peer: far-side serial device that drives the receive line.
// assumes the bench commands the level to send; idles high from time zero.
`timescale 1ns/1ps
`default_nettype none
module umc_peer (
	input  wire logic aclk,
	input  wire logic send_lvl,
	output logic      rx_pin
);
	// line moves only just after an edge, like a registered driver
	always @(posedge aclk) begin
		rx_pin <= send_lvl;
	end
	initial rx_pin = 1'b1;
endmodule
`default_nettype wire
